// ### dv/dsu_ctrl_sva.sv
/* dsu_ctrl_sva: bus, command and dma checks on the dsu_ctrl ports.
   Assumes: one hclk domain, hready tied to hreadyout. */
module dsu_ctrl_sva (
  input wire logic       hclk,
  input wire logic       hresetn,
  input wire logic       hsel,
  input wire logic [1:0] htrans,
  input wire logic       hready,
  input wire logic       hreadyout,
  input wire logic       hresp,
  input wire logic       eng_rx_en,
  input wire logic       eng_tx_en,
  input wire logic       eng_rx_rst,
  input wire logic       eng_tx_rst,
  input wire logic       eng_rx_done,
  input wire logic       eng_tx_load,
  input wire logic       dma_rx_req,
  input wire logic       dma_wr,
  input wire logic       dma_rd,
  input wire logic [5:0] dma_addr
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking dc @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // request accepted while the slave is idle
  sequence taken_s;
    hsel && hready && htrans[1] && hreadyout;
  endsequence
  // exactly one wait state, then ready again
  sequence one_wait_s;
    !hreadyout ##1 hreadyout;
  endsequence
  bus_wait_a: assert property (taken_s |=> one_wait_s)
    else $error("bus answer not after one wait");
  hresp_okay_a: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  dma_window_a: assert property ((dma_wr || dma_rd) |-> dma_addr <= 6'h09)
    else $error("dma access off window");
  dma_pulse_a: assert property (dma_wr |=> !dma_wr)
    else $error("dma write pulse too long");
  rx_request_a: assert property (eng_rx_done && eng_rx_en |=> dma_rx_req)
    else $error("no rx dma request");
  tx_load_a: assert property (eng_tx_load |-> eng_tx_en)
    else $error("load while tx off");
  rx_reset_a: assert property (eng_rx_rst |-> !eng_rx_en ##1 !eng_rx_rst)
    else $error("rx reset left rx on");
  tx_reset_a: assert property (eng_tx_rst |-> !eng_tx_en ##1 !eng_tx_rst)
    else $error("tx reset left tx on");
endmodule // dsu_ctrl_sva

bind dsu_ctrl dsu_ctrl_sva dsu_ctrl_sva_inst (.*);

// ### dv/dsu_term.sv
/* dsu_term: remote terminal, drives the serial input and watches the output.
   Assumes: the bench sets send_level just after a clock edge. */
module dsu_term (
  input wire logic hclk,
  input wire logic send_level,
  input wire logic serial_out_pin,
  output logic     serial_in_pin,
  output logic     seen_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // line is always driven, so it never floats between frames
  always_ff @(posedge hclk) begin
    serial_in_pin <= send_level;
    seen_out      <= serial_out_pin;
  end
endmodule // dsu_term

// ### dv/testbench.sv
/* testbench: register, interrupt, line mode, rx, tx and dma scenarios.
   Assumes: dsu_ctrl with checker bound, dsu_term on the serial pins. */
module testbench
  import dsu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] PID = 32'h12345678;  // arbitrary, extension flag clear
  localparam logic [3:0] OUT0 = 4'h5, OUT1 = 4'he, RX0 = 4'hc, RX1 = 4'hb;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] hwdata = 32'h0, rd, hrdata, dma_wdata, dw_data;
  logic        eng_tx_line = 1'b1, eng_rx_done = 1'b0, eng_rx_par_err = 1'b0;
  logic        eng_rx_frm_err = 1'b0, eng_rx_busy = 1'b0, tx_hold = 1'b0, dma_end_rx = 1'b0;
  logic        debug_in_pending = 1'b0, debug_out_pending = 1'b0, send_level = 1'b1;
  logic [7:0]  eng_rx_char = 8'h00, eng_tx_char;
  logic [3:0]  tx_cnt = 4'h0;
  logic        hreadyout, hresp, serial_in_pin, serial_out_pin, seen_out, eng_rx_line;
  logic        eng_rx_en, eng_tx_en, eng_rx_rst, eng_tx_rst, eng_tx_load, eng_tx_busy;
  logic        dma_rx_req, dma_tx_req, dma_wr, dma_rd, ice_test_reset_hold, irq;
  logic [2:0]  eng_parity;
  logic [15:0] eng_divisor;
  logic [5:0]  dma_addr, dw_addr;
  wire [31:0]  dma_rdata = dma_rd ? {26'h0, dma_addr} : 32'h0;
  int          fails = 0, n_compared = 0;
  always #20 hclk = ~hclk;
  // shifter stand-in: busy if held or six cycles after load
  assign eng_tx_busy = tx_hold | (tx_cnt != 4'h0);
  always @(posedge hclk) begin
    if (eng_tx_load === 1'b1) tx_cnt <= 4'h6;
    else if (tx_cnt != 4'h0) tx_cnt <= tx_cnt - 4'h1;
    if (dma_wr === 1'b1) begin
      dw_addr <= dma_addr;
      dw_data <= dma_wdata;
    end
  end
  dsu_ctrl #(.PART_ID(PID), .PART_EXT(32'h000000a5)) dsu_ctrl_inst (.*, .hsize(3'h2),
    .hready(hreadyout), .dma_end_tx(1'b0), .dma_tx_bufe(1'b0), .dma_rx_buff(1'b0));
  dsu_term dsu_term_inst (.*);
  task print_verdict;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task cyc(input int k);
    repeat (k) @(posedge hclk);
  endtask
  // hold address, then data, each until ready
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 20);
    htrans <= 2'h0;
    hwdata <= d;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 40);
    rd = hrdata;
    if (n >= 40) begin
      fails++;
      print_verdict;
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task rdc(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task t_regs;
    rdc(DSU_MODE_OFS, DSU_MODE_RST);
    rdc(DSU_IEVW_OFS, DSU_IMR_RST);
    rdc(DSU_DIV_OFS, 32'h0);
    rdc(DSU_LOCK_OFS, 32'h0);
    rdc(DSU_PID_OFS, PID);
    rdc(DSU_PIDX_OFS, 32'h0);
    rdc(12'h030, 32'h0);
    wr(DSU_PID_OFS, 32'h0);
    rdc(DSU_PID_OFS, PID);
    wr(DSU_MODE_OFS, 32'hffffffff);
    rdc(DSU_MODE_OFS, 32'h0000ce00);
    for (int k = 0; k < 8; k++) begin
      wr(DSU_MODE_OFS, k << 9);
      cyc(2);
      chk(eng_parity, k[2:0]);
    end
    wr(DSU_DIV_OFS, 32'h1234);
    wr(DSU_LOCK_OFS, 32'h1);
    cyc(2);
    chk(eng_divisor, 16'h1234);
    chk(ice_test_reset_hold, 1'b1);
    wr(DSU_LOCK_OFS, 32'h0);
    $display("done t_regs");
  endtask
  task t_irq;
    wr(DSU_IESET_OFS, 32'hc0000000);
    wr(DSU_IESET_OFS, 32'h0);
    rdc(DSU_IEVW_OFS, 32'hc0000000);
    debug_in_pending <= 1'b1;
    cyc(3);
    rdc(DSU_STAT_OFS, 32'h80000000);
    chk(irq, 1'b1);
    wr(DSU_IECLR_OFS, 32'h80000000);
    rdc(DSU_IEVW_OFS, 32'h40000000);
    cyc(2);
    chk(irq, 1'b0);
    debug_out_pending <= 1'b1;
    cyc(3);
    rdc(DSU_STAT_OFS, 32'hc0000000);
    chk(irq, 1'b1);
    wr(DSU_IECLR_OFS, 32'hffffffff);
    debug_in_pending <= 1'b0;
    debug_out_pending <= 1'b0;
    rdc(DSU_IEVW_OFS, 32'h0);
    $display("done t_irq");
  endtask
  task rx_char(input logic [7:0] c, input logic e);
    eng_rx_char <= c;
    eng_rx_par_err <= e;
    eng_rx_frm_err <= e;
    eng_rx_done <= 1'b1;
    @(posedge hclk);
    eng_rx_done <= 1'b0;
    cyc(2);
  endtask
  task t_rx;
    wr(DSU_CMD_OFS, 32'h30);
    cyc(2);
    chk(eng_rx_en, 1'b0);
    wr(DSU_CMD_OFS, 32'h10);
    cyc(2);
    chk(eng_rx_en, 1'b1);
    rx_char(8'h5a, 1'b1);
    rx_char(8'h5a, 1'b1);
    chk(dma_rx_req, 1'b1);
    rdc(DSU_STAT_OFS, 32'h000000e1);
    rdc(DSU_RXCH_OFS, 32'h5a);
    cyc(2);
    chk(dma_rx_req, 1'b0);
    wr(DSU_CMD_OFS, 32'h100);
    rdc(DSU_STAT_OFS, 32'h0);
    eng_rx_busy <= 1'b1;
    wr(DSU_CMD_OFS, 32'h20);
    cyc(2);
    chk(eng_rx_en, 1'b1);
    eng_rx_busy <= 1'b0;
    rx_char(8'h11, 1'b0);
    chk(eng_rx_en, 1'b0);
    wr(DSU_CMD_OFS, 32'h10);
    eng_rx_busy <= 1'b1;
    wr(DSU_CMD_OFS, 32'h24);
    cyc(2);
    chk(eng_rx_en, 1'b0);
    chk(dma_rx_req, 1'b0);
    eng_rx_busy <= 1'b0;
    $display("done t_rx");
  endtask
  task t_modes;
    wr(DSU_CMD_OFS, 32'h40);
    for (int m = 0; m < 4; m++) begin
      for (int c = 0; c < 2; c++) begin
        wr(DSU_MODE_OFS, m << 14);
        send_level <= c[0];
        eng_tx_line <= ~c[0];
        cyc(10);
        chk(seen_out, c ? OUT1[m] : OUT0[m]);
        chk(eng_rx_line, c ? RX1[m] : RX0[m]);
      end
    end
    wr(DSU_MODE_OFS, 32'h0);
    send_level <= 1'b1;
    eng_tx_line <= 1'b1;
    $display("done t_modes");
  endtask
  task t_tx;
    int n;
    wr(DSU_CMD_OFS, 32'hc0);
    cyc(2);
    chk(eng_tx_en, 1'b0);
    wr(DSU_CMD_OFS, 32'h40);
    cyc(2);
    chk(eng_tx_en, 1'b1);
    chk(dma_tx_req, 1'b1);
    rdc(DSU_STAT_OFS, 32'h00000202);
    tx_hold <= 1'b1;
    wr(DSU_TXCH_OFS, 32'h3c);
    cyc(2);
    chk(dma_tx_req, 1'b0);
    wr(DSU_CMD_OFS, 32'h80);
    cyc(2);
    chk(eng_tx_en, 1'b1);
    tx_hold <= 1'b0;
    for (n = 0; n < 20 && eng_tx_load !== 1'b1; n++) @(posedge hclk);
    chk(eng_tx_load, 1'b1);
    chk(eng_tx_char, 32'h3c);
    cyc(2);
    chk(eng_tx_en, 1'b1);
    cyc(10);
    chk(eng_tx_en, 1'b0);
    wr(DSU_CMD_OFS, 32'h40);
    tx_hold <= 1'b1;
    wr(DSU_TXCH_OFS, 32'h55);
    wr(DSU_CMD_OFS, 32'h88);
    cyc(2);
    chk(eng_tx_en, 1'b0);
    tx_hold <= 1'b0;
    $display("done t_tx");
  endtask
  task t_dma;
    wr(12'h104, 32'hdeadbeef);
    cyc(2);
    chk(dw_addr, 32'h1);
    chk(dw_data, 32'hdeadbeef);
    rdc(12'h124, 32'h9);
    dma_end_rx <= 1'b1;
    rdc(DSU_STAT_OFS, 32'h8);
    $display("done t_dma");
  endtask
  initial begin
    cyc(2);
    hresetn <= 1'b1;
    t_regs;
    t_irq;
    t_rx;
    t_modes;
    t_tx;
    t_dma;
    print_verdict;
  end
endmodule // testbench

// ### logic/dsu_ctrl.sv
/*
  dsu_ctrl: control side of a debug serial unit. AHB-Lite register slave,
  command/mode/interrupt-enable registers, status, dma request hooks,
  line test mode routing, identity registers and debug port lock.
  Assumes: a bit engine on hclk (baud divider, sampler, shifter) connected
  on the eng_* ports; a dma block on hclk on the dma_* ports; debug
  channel flags synchronous to hclk; serial_in_pin asynchronous.
*/
// Functional notes
// - dma channel registers mapped from 0x100
// - rx char waiting requests receive dma
// - tx holding free requests transmit dma
// - mode bits 15:14 select line mode
// - echo: input pin drives output pin
// - local loopback: tx feeds rx, out high
// - remote loopback: pins joined, engines ignored but left enabled
// - status 31/30 show debug channel flags
// - extension id reads zero unless flagged
// - first id holds part description fields
// - lock bit holds test reset asserted
// - lock bit resets to zero
// - rx reset aborts and disables receiver
// - tx reset aborts and disables transmitter
// - rx enable unless disable same write
// - rx disable after current character
// - tx enable unless disable same write
// - tx disable after shifter and holding drain
// - clear command clears three error flags
// - mode bits 11:9 select parity kind
// - enable-set register sets mask bits
// - enable-clear register clears mask bits
// - enable view shows mask bits
module dsu_ctrl
  import dsu_pkg::*;
#(
  parameter logic [31:0] PART_ID  = 32'h80000001,  // arbitrary value
  parameter logic [31:0] PART_EXT = 32'h00000000,  // arbitrary value
  parameter int          ADDR_W   = 12
) (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [ADDR_W-1:0] haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic              hready,
  input  wire logic [31:0]       hwdata,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  input  wire logic              serial_in_pin,
  output logic                   serial_out_pin,
  input  wire logic              eng_tx_line,
  output logic                   eng_rx_line,
  output logic                   eng_rx_en,
  output logic                   eng_tx_en,
  output logic                   eng_rx_rst,
  output logic                   eng_tx_rst,
  output logic      [2:0]        eng_parity,
  output logic      [15:0]       eng_divisor,
  input  wire logic              eng_rx_done,
  input  wire logic [7:0]        eng_rx_char,
  input  wire logic              eng_rx_par_err,
  input  wire logic              eng_rx_frm_err,
  input  wire logic              eng_rx_busy,
  input  wire logic              eng_tx_busy,
  output logic                   eng_tx_load,
  output logic      [7:0]        eng_tx_char,
  output logic                   dma_rx_req,
  output logic                   dma_tx_req,
  input  wire logic              dma_end_rx,
  input  wire logic              dma_end_tx,
  input  wire logic              dma_tx_bufe,
  input  wire logic              dma_rx_buff,
  output logic                   dma_wr,
  output logic                   dma_rd,
  output logic      [5:0]        dma_addr,
  output logic      [31:0]       dma_wdata,
  input  wire logic [31:0]       dma_rdata,
  input  wire logic              debug_in_pending,
  input  wire logic              debug_out_pending,
  output logic                   ice_test_reset_hold,
  output logic                   irq
);

  // the decoder compares the low twelve address bits
  if (ADDR_W < 12) begin : g_chk
    $error("dsu_ctrl: ADDR_W must be at least 12");
  end

  // window test used by read and write decode alike
  function automatic logic in_dma(input logic [11:0] a);
    in_dma = (a >= DSU_DMA_FIRST) && (a <= DSU_DMA_LAST);
  endfunction

  // bus slave state
  dsu_bus_t         phase_r;      // address or data phase
  logic [11:0]      adr_r;        // latched address
  logic             wr_r;         // latched direction
  logic [31:0]      hrdata_r;     // read data
  logic             hready_r;     // ready out
  logic             dma_wr_r;     // dma window write strobe
  logic             dma_rd_r;     // dma window read strobe
  logic [5:0]       dma_addr_r;   // dma window offset
  logic [31:0]      dma_wdata_r;  // dma window data
  // software registers
  logic [31:0]      mode_r;       // line mode register
  logic [15:0]      div_r;        // bit rate divisor
  logic [31:0]      imr_r;        // interrupt enable mask
  logic             lock_r;       // debug port lock
  // channel state
  logic             rx_en_r;      // receiver enabled
  logic             tx_en_r;      // transmitter enabled
  logic             rx_off_r;     // rx disable pending
  logic             tx_off_r;     // tx disable pending
  logic             rx_rst_r;     // rx reset pulse
  logic             tx_rst_r;     // tx reset pulse
  logic             rx_char_waiting_r;      // char waiting
  logic             ovr_r;        // overrun flag
  logic             frm_r;        // framing flag
  logic             par_r;        // parity flag
  logic [7:0]       rxch_r;       // received char
  logic             thr_full_r;   // holding reg occupied
  logic [7:0]       thr_r;        // holding reg contents
  logic             load_r;       // holding -> shifter pulse
  logic             txreq_r;      // tx dma request
  logic             irq_r;        // interrupt out
  // pin synchroniser and line routing
  logic             s1_r;         // first stage, read only by s2
  logic             s2_r;
  logic             s3_r;
  logic             rxd_r;        // filtered pin level
  logic             sout_r;       // registered out pin
  logic             erx_r;        // registered engine rx line

  // address phase and decode
  wire              take     = hsel & hready & htrans[1];
  wire              dwr      = (phase_r == DSU_DATA) & wr_r;
  wire              drd      = (phase_r == DSU_DATA) & ~wr_r;
  wire              wr_cmd   = dwr & (adr_r == DSU_CMD_OFS);
  wire              wr_mode  = dwr & (adr_r == DSU_MODE_OFS);
  wire              wr_ieset = dwr & (adr_r == DSU_IESET_OFS);
  wire              wr_ieclr = dwr & (adr_r == DSU_IECLR_OFS);
  wire              wr_thr   = dwr & (adr_r == DSU_TXCH_OFS);
  wire              wr_div   = dwr & (adr_r == DSU_DIV_OFS);
  wire              wr_lock  = dwr & (adr_r == DSU_LOCK_OFS);
  wire              rd_rhr   = drd & (adr_r == DSU_RXCH_OFS);
  wire              tk_dma   = take & in_dma(haddr[11:0]);
  wire [11:0]       tk_ofs   = haddr[11:0] - DSU_DMA_FIRST;

  // command bits, live only during a command write
  wire              c_rxrst = wr_cmd & hwdata[DSU_CMD_RX_RST];
  wire              c_txrst = wr_cmd & hwdata[DSU_CMD_TX_RST];
  wire              c_rxon  = wr_cmd & hwdata[DSU_CMD_RX_ON];
  wire              c_rxoff = wr_cmd & hwdata[DSU_CMD_RX_OFF];
  wire              c_txon  = wr_cmd & hwdata[DSU_CMD_TX_ON];
  wire              c_txoff = wr_cmd & hwdata[DSU_CMD_TX_OFF];
  wire              c_clr   = wr_cmd & hwdata[DSU_CMD_CLR];

  // line mode and engine gating
  wire dsu_channel_test_select_t chm    = dsu_channel_test_select_t'(mode_r[DSU_CHM_LO +: 2]);
  wire              remote = (chm == DSU_REMOTE);
  wire              rx_act = rx_en_r & ~remote;
  wire              tx_act = tx_en_r & ~remote;
  wire              rx_got = eng_rx_done & rx_act;

  // transmit holding path
  wire              tx_holding_free   = tx_act & ~thr_full_r;
  wire              txempty = tx_holding_free & ~eng_tx_busy & ~load_r;
  wire              do_load = thr_full_r & tx_act & ~eng_tx_busy & ~load_r;

  // status word
  wire [31:0]       status;
  assign status[DSU_ST_RX_CHAR_WAITING] = rx_char_waiting_r;
  assign status[DSU_ST_TX_HOLDING_FREE] = tx_holding_free;
  assign status[2]            = 1'b0;
  assign status[DSU_ST_ENDRX] = dma_end_rx;
  assign status[DSU_ST_ENDTX] = dma_end_tx;
  assign status[DSU_ST_OVR]   = ovr_r;
  assign status[DSU_ST_FRAME] = frm_r;
  assign status[DSU_ST_PAR]   = par_r;
  assign status[8]            = 1'b0;
  assign status[DSU_ST_TXEMP] = txempty;
  assign status[10]           = 1'b0;
  assign status[DSU_ST_TXBE]  = dma_tx_bufe;
  assign status[DSU_ST_RXBF]  = dma_rx_buff;
  assign status[29:13]        = 17'h00000;
  assign status[DSU_ST_DOUT]  = debug_out_pending;
  assign status[DSU_ST_DIN]   = debug_in_pending;

  // identity, extension hidden unless flagged
  wire [31:0] pid  = PART_ID;
  wire [31:0] pidx = pid[DSU_PID_EXT] ? PART_EXT : 32'h00000000;

  // read mux, unmapped offsets read zero
  wire [31:0] rmux =
    (adr_r == DSU_MODE_OFS) ? (mode_r & DSU_MODE_MASK) :
    (adr_r == DSU_IEVW_OFS) ? imr_r :
    (adr_r == DSU_STAT_OFS) ? status :
    (adr_r == DSU_RXCH_OFS) ? {24'h000000, rxch_r} :
    (adr_r == DSU_DIV_OFS)  ? {16'h0000, div_r} :
    (adr_r == DSU_PID_OFS)  ? pid :
    (adr_r == DSU_PIDX_OFS) ? pidx :
    (adr_r == DSU_LOCK_OFS) ? {31'h00000000, lock_r} :
    in_dma(adr_r)           ? dma_rdata :
    32'h00000000;

  // bus phase sequencing; one wait state lets reads come from a flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_r  <= DSU_ADDR;
      adr_r    <= 12'h000;
      wr_r     <= 1'b0;
      hready_r <= 1'b1;
      hrdata_r <= 32'h00000000;
    end else if (phase_r == DSU_ADDR) begin
      if (take) begin
        phase_r  <= DSU_DATA;
        adr_r    <= {haddr[11:2], 2'b00};
        wr_r     <= hwrite;
        hready_r <= 1'b0;
      end
    end else begin
      // data phase: finish and release
      phase_r  <= DSU_ADDR;
      hready_r <= 1'b1;
      hrdata_r <= wr_r ? 32'h00000000 : rmux;
    end
  end

  // dma window pass-through strobes, read with the address phase, write with the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dma_wr_r    <= 1'b0;
      dma_rd_r    <= 1'b0;
      dma_addr_r  <= 6'h00;
      dma_wdata_r <= 32'h00000000;
    end else begin
      dma_rd_r <= tk_dma & ~hwrite & (phase_r == DSU_ADDR);
      dma_wr_r <= dwr & in_dma(adr_r);
      if (tk_dma && phase_r == DSU_ADDR) begin
        dma_addr_r <= tk_ofs[7:2];
      end
      if (dwr) begin
        dma_wdata_r <= hwdata;
      end
    end
  end

  // software configuration registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_r <= DSU_MODE_RST;
      div_r  <= DSU_DIV_RST;
      lock_r <= DSU_LOCK_RST;
    end else begin
      if (wr_mode) begin
        mode_r <= hwdata & DSU_MODE_MASK;
      end
      if (wr_div) begin
        div_r <= hwdata[15:0];
      end
      if (wr_lock) begin
        lock_r <= hwdata[0];
      end
    end
  end

  // interrupt mask: set-register ones enable, clear-register ones disable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      imr_r <= DSU_IMR_RST;
    end else if (wr_ieset) begin
      imr_r <= imr_r | (hwdata & DSU_ST_IMPL);
    end else if (wr_ieclr) begin
      imr_r <= imr_r & ~hwdata;
    end
  end

  // receiver enable; reset beats disable beats enable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_en_r  <= 1'b0;
      rx_off_r <= 1'b0;
      rx_rst_r <= 1'b0;
    end else begin
      rx_rst_r <= c_rxrst;
      if (c_rxrst) begin
        rx_en_r  <= 1'b0;
        rx_off_r <= 1'b0;
      end else if (c_rxoff) begin
        // a char in flight is finished first
        rx_off_r <= eng_rx_busy & rx_en_r;
        rx_en_r  <= eng_rx_busy & rx_en_r;
      end else if (c_rxon) begin
        rx_en_r  <= 1'b1;
        rx_off_r <= 1'b0;
      end else if (rx_off_r && !eng_rx_busy) begin
        rx_en_r  <= 1'b0;
        rx_off_r <= 1'b0;
      end
    end
  end

  // transmitter enable; disable waits for holding and shifter to drain
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_en_r  <= 1'b0;
      tx_off_r <= 1'b0;
      tx_rst_r <= 1'b0;
    end else begin
      tx_rst_r <= c_txrst;
      if (c_txrst) begin
        tx_en_r  <= 1'b0;
        tx_off_r <= 1'b0;
      end else if (c_txoff) begin
        tx_off_r <= tx_en_r;
      end else if (c_txon) begin
        tx_en_r  <= 1'b1;
        tx_off_r <= 1'b0;
      end else if (tx_off_r && txempty) begin
        tx_en_r  <= 1'b0;
        tx_off_r <= 1'b0;
      end
    end
  end

  // receive flags; a new event wins over a clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_char_waiting_r <= 1'b0;
      ovr_r   <= 1'b0;
      frm_r   <= 1'b0;
      par_r   <= 1'b0;
      rxch_r  <= DSU_RXCH_RST;
    end else begin
      if (rx_got) begin
        rx_char_waiting_r <= 1'b1;
        rxch_r  <= eng_rx_char;
      end else if (rd_rhr || c_rxrst) begin
        rx_char_waiting_r <= 1'b0;
      end
      // clear command drops errors unless a new one arrives now
      ovr_r <= (rx_got & rx_char_waiting_r) | (ovr_r & ~c_clr);
      frm_r <= (rx_got & eng_rx_frm_err) | (frm_r & ~c_clr);
      par_r <= (rx_got & eng_rx_par_err) | (par_r & ~c_clr);
    end
  end

  // transmit holding register and shifter hand-off
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      thr_full_r <= 1'b0;
      thr_r      <= 8'h00;
      load_r     <= 1'b0;
      txreq_r    <= 1'b0;
    end else begin
      load_r <= do_load & ~c_txrst;
      // drops with the write that fills holding
      txreq_r <= tx_holding_free & ~wr_thr & ~c_txrst;
      if (c_txrst) begin
        thr_full_r <= 1'b0;
      end else if (wr_thr && tx_act) begin
        // writes while full overwrite the waiting char
        thr_full_r <= 1'b1;
        thr_r      <= hwdata[7:0];
      end else if (do_load) begin
        thr_full_r <= 1'b0;
      end
    end
  end

  // interrupt line
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(status & imr_r);
    end
  end

  // pin synchroniser: a change counts once stages two and three agree
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_r  <= 1'b1;
      s2_r  <= 1'b1;
      s3_r  <= 1'b1;
      rxd_r <= 1'b1;
    end else begin
      s1_r <= serial_in_pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        rxd_r <= s3_r;
      end
    end
  end

  // line routing per test mode; out pin idles high from reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sout_r <= 1'b1;
      erx_r  <= 1'b1;
    end else begin
      case (chm)
        DSU_ECHO: begin
          sout_r <= rxd_r;
          erx_r  <= rxd_r;
        end
        DSU_LOCAL: begin
          sout_r <= 1'b1;
          erx_r  <= eng_tx_line;
        end
        DSU_REMOTE: begin
          sout_r <= rxd_r;
          erx_r  <= 1'b1;
        end
        default: begin
          sout_r <= eng_tx_line;
          erx_r  <= rxd_r;
        end
      endcase
    end
  end

  // outputs, each straight from a flop except hresp, tied low
  assign hrdata              = hrdata_r;
  assign hreadyout           = hready_r;
  assign hresp               = 1'b0;
  assign serial_out_pin      = sout_r;
  assign eng_rx_line         = erx_r;
  assign eng_rx_en           = rx_en_r;
  assign eng_tx_en           = tx_en_r;
  assign eng_rx_rst          = rx_rst_r;
  assign eng_tx_rst          = tx_rst_r;
  assign eng_parity          = mode_r[DSU_PAR_LO +: 3];
  assign eng_divisor         = div_r;
  assign eng_tx_load         = load_r;
  assign eng_tx_char         = thr_r;
  assign dma_rx_req          = rx_char_waiting_r;
  assign dma_tx_req          = txreq_r;
  assign dma_wr              = dma_wr_r;
  assign dma_rd              = dma_rd_r;
  assign dma_addr            = dma_addr_r;
  assign dma_wdata           = dma_wdata_r;
  assign ice_test_reset_hold = lock_r;
  assign irq                 = irq_r;

endmodule // dsu_ctrl

// ### logic/dsu_pkg.sv
/*
  dsu_pkg: register map, field positions, reset values and enumerations
  for the debug serial unit control block.
  Assumes: included before logic/dsu_ctrl.sv; nothing else.
*/
package dsu_pkg;

  // register byte offsets within the unit
  localparam logic [11:0] DSU_CMD_OFS   = 12'h000;  // command, write only
  localparam logic [11:0] DSU_MODE_OFS  = 12'h004;  // line mode
  localparam logic [11:0] DSU_IESET_OFS = 12'h008;  // interrupt enable set
  localparam logic [11:0] DSU_IECLR_OFS = 12'h00c;  // interrupt enable clear
  localparam logic [11:0] DSU_IEVW_OFS  = 12'h010;  // interrupt enable view
  localparam logic [11:0] DSU_STAT_OFS  = 12'h014;  // line status
  localparam logic [11:0] DSU_RXCH_OFS  = 12'h018;  // received char
  localparam logic [11:0] DSU_TXCH_OFS  = 12'h01c;  // char to send
  localparam logic [11:0] DSU_DIV_OFS   = 12'h020;  // bit rate divisor
  localparam logic [11:0] DSU_PID_OFS   = 12'h040;  // part identity
  localparam logic [11:0] DSU_PIDX_OFS  = 12'h044;  // identity extension
  localparam logic [11:0] DSU_LOCK_OFS  = 12'h048;  // debug port lock
  localparam logic [11:0] DSU_DMA_FIRST = 12'h100;  // dma channel window
  localparam logic [11:0] DSU_DMA_LAST  = 12'h124;

  // command register bit positions
  localparam int DSU_CMD_RX_RST = 2;
  localparam int DSU_CMD_TX_RST = 3;
  localparam int DSU_CMD_RX_ON  = 4;
  localparam int DSU_CMD_RX_OFF = 5;
  localparam int DSU_CMD_TX_ON  = 6;
  localparam int DSU_CMD_TX_OFF = 7;
  localparam int DSU_CMD_CLR    = 8;

  // mode register fields
  localparam int DSU_PAR_LO = 9;   // check_bit_kind 11:9
  localparam int DSU_CHM_LO = 14;  // channel_test_select 15:14
  localparam logic [31:0] DSU_MODE_MASK = 32'h0000ce00;

  // status bit positions
  localparam int DSU_ST_RX_CHAR_WAITING = 0;
  localparam int DSU_ST_TX_HOLDING_FREE = 1;
  localparam int DSU_ST_ENDRX = 3;
  localparam int DSU_ST_ENDTX = 4;
  localparam int DSU_ST_OVR   = 5;
  localparam int DSU_ST_FRAME = 6;
  localparam int DSU_ST_PAR   = 7;
  localparam int DSU_ST_TXEMP = 9;
  localparam int DSU_ST_TXBE  = 11;
  localparam int DSU_ST_RXBF  = 12;
  localparam int DSU_ST_DOUT  = 30;
  localparam int DSU_ST_DIN   = 31;
  localparam logic [31:0] DSU_ST_IMPL = 32'hc0001afb;

  // identity fields
  localparam int DSU_PID_EXT = 31;  // second_id_valid

  // reset values
  localparam logic [31:0] DSU_MODE_RST = 32'h00000000;
  localparam logic [31:0] DSU_IMR_RST  = 32'h00000000;
  localparam logic [15:0] DSU_DIV_RST  = 16'h0000;
  localparam logic        DSU_LOCK_RST = 1'b0;
  localparam logic [7:0]  DSU_RXCH_RST = 8'h00;

  // bus phase, gray along idle -> data -> idle
  typedef enum logic {
    DSU_ADDR = 1'b0,
    DSU_DATA = 1'b1
  } dsu_bus_t;

  // line test modes
  typedef enum logic [1:0] {
    DSU_NORMAL = 2'b00,
    DSU_ECHO   = 2'b01,
    DSU_LOCAL  = 2'b10,
    DSU_REMOTE = 2'b11
  } dsu_channel_test_select_t;

endpackage
